// [src/pcm_consts.svh]
// Purpose: Constants for the time-slotted PCM voice port.
// Assumes: 100 MHz system clock, APB register access with 32-bit data.
// Notes: Definitions only.
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PCM_REG_CTRL 8'h00
`define PCM_REG_SLOTMAP 8'h04
`define PCM_REG_TXDATA 8'h08
`define PCM_REG_STATUS 8'h0c
`define PCM_REG_RX0 8'h10
`define PCM_REG_RX1 8'h14
`define PCM_REG_RX2 8'h18
`define PCM_CTRL_RESET 32'h0000_0000
`define PCM_SLOTMAP_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define PCM_CHANNELS 3
`define PCM_SLOTMAP_STRIDE 8
`define PCM_SLOTMAP_EN_BIT 4
`define PCM_FILL_ZERO 2'h0
`define PCM_FILL_ONE 2'h1
`define PCM_FILL_SIGN 2'h2
`define PCM_FILL_VALUE 2'h3
`define PCM_RATE_LOW 2'h0
`define PCM_RATE_MID 2'h1
`define PCM_RATE_HIGH 2'h2
`define PCM_TX_FIFO_DEPTH 4
`define PCM_SAMPLE_BITS 13
`define PCM_LONG_SYNC_BITS 8'h03

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCM_SYS_CLK_KHZ 100000
`define PCM_RATE_LOW_KHZ 128
`define PCM_RATE_MID_KHZ 512
`define PCM_RATE_HIGH_KHZ 1024
`define PCM_RATE_BURST_KHZ 24000
`define PCM_HALF(r) ((`PCM_SYS_CLK_KHZ + 2 * (r) - 1) / (2 * (r)))
`define PCM_LAST_LOW 8'h0f
`define PCM_LAST_MID_8K 8'h3f
`define PCM_LAST_MID_16K 8'h1f
`define PCM_LAST_HIGH_8K 8'h7f
`define PCM_LAST_HIGH_16K 8'h3f
`define PCM_LAST_BURST 8'hff

`endif

// [src/pcm_pkg.sv]
// Purpose: Types for the time-slotted PCM voice port.
// Assumes: Nothing beyond the constants header.
// Notes: The control word layout is the layout of the control register.
package pcm_pkg;
    typedef struct packed {
        logic [16:0] rsvd;
        logic [2:0] fill_val;
        logic lsb_first;
        logic [1:0] pos;
        logic [1:0] fill_mode;
        logic burst_req;
        logic fs16;
        logic [1:0] rate;
        logic long_sync;
        logic master;
        logic enable;
    } ctrl_type;

    typedef struct packed {
        logic hit;
        logic [1:0] ch;
    } slot_hit_type;
endpackage : pcm_pkg

// [src/pcm_voice_port.sv]
// Purpose: Time-slotted PCM voice port with APB registers and transmit FIFO.
// Assumes: Pins are asynchronous to sys_clk and pass two flip-flops.
// Notes: The bit clock must be well below a quarter of sys_clk in slave mode.
//
// Operation
// - Up to three full-duplex channels share port.
// - Frame at 8 or 16 kHz outside burst mode; up to sixteen slots.
// - Bit clock rate selects slots per frame.
// - Channel transmits and receives in same slot.
// - Output released on unassigned slots.
// - Release follows falling edge of slot's last bit.
// - Short and long sync in both modes.
// - Short sync: one bit wide, rising aligned.
// - Slave short: high at fall, next rise slot zero.
// - Long sync: three bits, starts with bit zero.
// - Thirteen sample bits, position and order configurable.
// - Spare bits ignored in, filled out as configured.
// - Default is left justified, MSB first.
// - Burst mode runs bit clock near 16.7 MHz (six sys_clk cycles).
// - Burst mode entered only after host request.
// - Master drives clock and sync; slave receives them.
`include "pcm_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Transmit sample FIFO
// ----------------------------------------------------------------------
module pcm_fifo #(
    parameter int WIDTH = `PCM_SAMPLE_BITS,
    parameter int DEPTH = `PCM_TX_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = count != DEPTH[AW:0];
    assign out_valid = count != '0;
    assign out_data = mem[rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr <= wptr + 1'b1;
            end
            if (pop)
            begin
                rptr <= rptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : pcm_fifo

// ----------------------------------------------------------------------
// Port top
// ----------------------------------------------------------------------
module pcm_voice_port (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pcm_clk_in,
    output logic pcm_clk_out,
    output logic pcm_clk_oe,
    input wire logic pcm_sync_in,
    output logic pcm_sync_out,
    output logic pcm_sync_oe,
    input wire logic pcm_din,
    output logic pcm_dout,
    output logic pcm_dout_oe
);
    pcm_pkg::ctrl_type ctrl;
    logic [31:0] slotmap;
    logic underrun;
    logic burst_active;
    logic [12:0] rx_sample [`PCM_CHANNELS];
    logic [7:0] addr;
    logic access;
    logic mapped;
    logic tx_sel;
    logic reg_wr;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [12:0] fifo_out_data;
    logic clk_s1, clk_s2, clk_prev;
    logic sync_s1, sync_s2, sync_fall_prev;
    logic din_s1, din_s2;
    logic [8:0] half_cnt;
    logic [8:0] half_lim;
    logic gen_clk;
    logic gen_tick;
    logic bit_rise;
    logic bit_fall;
    logic [7:0] bit_idx;
    logic [7:0] last_idx;
    logic [7:0] next_bit_idx;
    logic pend_zero;
    logic frame_seen;
    logic next_zero;
    logic next_seen;
    pcm_pkg::slot_hit_type cur_hit;
    pcm_pkg::slot_hit_type next_hit;
    logic [15:0] tx_word;
    logic [15:0] load_word;
    logic [15:0] cur_word;
    logic [15:0] rx_word;
    logic rx_done;
    logic [1:0] rx_ch;
    logic release_due;

    function automatic pcm_pkg::slot_hit_type lookup(input logic [31:0] map,
                                                     input logic [3:0] slot);
        pcm_pkg::slot_hit_type r;
        r = '0;
        for (int c = `PCM_CHANNELS - 1; c >= 0; c--)
        begin
            if (map[c * `PCM_SLOTMAP_STRIDE + `PCM_SLOTMAP_EN_BIT] &&
                map[c * `PCM_SLOTMAP_STRIDE +: 4] == slot)
            begin
                r.hit = 1'b1;
                r.ch = c[1:0];
            end
        end
        return r;
    endfunction : lookup

    function automatic logic [15:0] format_word(input logic [12:0] s,
                                                input pcm_pkg::ctrl_type c);
        logic [15:0] body;
        logic [15:0] mask;
        logic [15:0] fvw;
        logic [15:0] fill;
        body = {s, 3'b000} >> c.pos;
        mask = 16'hfff8 >> c.pos;
        fvw = {13'h0000, c.fill_val};
        unique case (c.fill_mode)
            `PCM_FILL_ZERO: fill = 16'h0000;
            `PCM_FILL_ONE: fill = 16'hffff;
            `PCM_FILL_SIGN: fill = {16{s[12]}};
            `PCM_FILL_VALUE: fill = (fvw >> c.pos) | (fvw << (5'd16 - {3'b000, c.pos}));
        endcase
        return body | (fill & ~mask);
    endfunction : format_word

    function automatic logic [12:0] extract(input logic [15:0] w, input logic [1:0] p);
        logic [15:0] t;
        t = w << p;
        return t[15:3];
    endfunction : extract

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign addr = paddr[7:0];
    assign access = psel && penable;
    assign tx_sel = addr == `PCM_REG_TXDATA;
    assign mapped = paddr[31:8] == 24'h000000 && (addr == `PCM_REG_CTRL ||
        addr == `PCM_REG_SLOTMAP || tx_sel || addr == `PCM_REG_STATUS ||
        addr == `PCM_REG_RX0 || addr == `PCM_REG_RX1 || addr == `PCM_REG_RX2);
    // A full FIFO holds the write in its access phase instead of losing it.
    assign pready = !(access && pwrite && tx_sel && mapped && !fifo_in_ready);
    assign pslverr = access && !mapped;
    assign reg_wr = access && pwrite && mapped;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `PCM_CTRL_RESET;
            slotmap <= `PCM_SLOTMAP_RESET;
        end
        else if (reg_wr && addr == `PCM_REG_CTRL)
        begin
            ctrl <= {17'h00000, pwdata[14:0]};
        end
        else if (reg_wr && addr == `PCM_REG_SLOTMAP)
        begin
            slotmap <= pwdata & 32'h001f_1f1f;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            unique case (addr)
                `PCM_REG_CTRL: prdata <= ctrl;
                `PCM_REG_SLOTMAP: prdata <= slotmap;
                `PCM_REG_STATUS: prdata <= {24'h000000, bit_idx[7:4], !fifo_out_valid,
                                            !fifo_in_ready, underrun, burst_active};
                `PCM_REG_RX0: prdata <= {19'h00000, rx_sample[0]};
                `PCM_REG_RX1: prdata <= {19'h00000, rx_sample[1]};
                `PCM_REG_RX2: prdata <= {19'h00000, rx_sample[2]};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    pcm_fifo #(
        .WIDTH(`PCM_SAMPLE_BITS),
        .DEPTH(`PCM_TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(reg_wr && tx_sel),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[12:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers and bit clock
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            {clk_s1, clk_s2, clk_prev} <= 3'b000;
            {sync_s1, sync_s2} <= 2'b00;
            {din_s1, din_s2} <= 2'b00;
        end
        else
        begin
            {clk_s1, clk_s2, clk_prev} <= {pcm_clk_in, clk_s1, clk_s2};
            {sync_s1, sync_s2} <= {pcm_sync_in, sync_s1};
            {din_s1, din_s2} <= {pcm_din, din_s1};
        end
    end

    always_comb
    begin
        if (burst_active)
        begin
            half_lim = 9'(`PCM_HALF(`PCM_RATE_BURST_KHZ));
            last_idx = `PCM_LAST_BURST;
        end
        else
        begin
            unique case (ctrl.rate)
                `PCM_RATE_MID: half_lim = 9'(`PCM_HALF(`PCM_RATE_MID_KHZ));
                `PCM_RATE_HIGH: half_lim = 9'(`PCM_HALF(`PCM_RATE_HIGH_KHZ));
                default: half_lim = 9'(`PCM_HALF(`PCM_RATE_LOW_KHZ));
            endcase
            unique case (ctrl.rate)
                `PCM_RATE_MID: last_idx = ctrl.fs16 ? `PCM_LAST_MID_16K : `PCM_LAST_MID_8K;
                `PCM_RATE_HIGH: last_idx = ctrl.fs16 ? `PCM_LAST_HIGH_16K : `PCM_LAST_HIGH_8K;
                default: last_idx = `PCM_LAST_LOW;
            endcase
        end
    end

    assign gen_tick = ctrl.enable && ctrl.master && half_cnt >= half_lim - 9'h001;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            half_cnt <= 9'h000;
            gen_clk <= 1'b0;
        end
        else if (!ctrl.enable || !ctrl.master)
        begin
            half_cnt <= 9'h000;
            gen_clk <= 1'b0;
        end
        else if (gen_tick)
        begin
            half_cnt <= 9'h000;
            gen_clk <= !gen_clk;
        end
        else
        begin
            half_cnt <= half_cnt + 9'h001;
        end
    end

    assign bit_rise = ctrl.enable && (ctrl.master ? gen_tick && !gen_clk : clk_s2 && !clk_prev);
    assign bit_fall = ctrl.enable && (ctrl.master ? gen_tick && gen_clk : !clk_s2 && clk_prev);
    assign pcm_clk_out = gen_clk;
    assign pcm_clk_oe = ctrl.master;
    assign pcm_sync_oe = ctrl.master;

    // ------------------------------------------------------------------
    // Frame and slot timing
    // ------------------------------------------------------------------
    assign next_zero = pend_zero || (ctrl.master && bit_idx == last_idx);
    // A master first spends one bit on the frame's last index, so the partner sees sync first.
    assign next_bit_idx = next_zero ? 8'h00 : (ctrl.master && !frame_seen) ? last_idx :
        (bit_idx == 8'hff ? bit_idx : bit_idx + 8'h01);
    assign next_seen = frame_seen || next_zero;
    assign cur_hit = frame_seen ? lookup(slotmap, bit_idx[7:4]) : '0;
    assign next_hit = next_seen ? lookup(slotmap, next_bit_idx[7:4]) : '0;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bit_idx <= 8'hff;
            pend_zero <= 1'b0;
            frame_seen <= 1'b0;
            sync_fall_prev <= 1'b0;
            burst_active <= 1'b0;
            pcm_sync_out <= 1'b0;
        end
        else if (!ctrl.enable)
        begin
            bit_idx <= 8'hff;
            pend_zero <= 1'b0;
            frame_seen <= 1'b0;
            burst_active <= 1'b0;
            pcm_sync_out <= 1'b0;
        end
        else if (bit_rise)
        begin
            bit_idx <= next_bit_idx;
            pend_zero <= 1'b0;
            frame_seen <= next_seen;
            if (next_zero)
            begin
                // Switching only on a frame edge keeps slot timing intact.
                burst_active <= ctrl.burst_req;
            end
            if (ctrl.long_sync)
            begin
                pcm_sync_out <= next_bit_idx < `PCM_LONG_SYNC_BITS;
            end
            else
            begin
                pcm_sync_out <= next_bit_idx == last_idx;
            end
        end
        else if (bit_fall)
        begin
            sync_fall_prev <= sync_s2;
            if (!ctrl.master && !ctrl.long_sync)
            begin
                pend_zero <= sync_s2;
            end
            else if (!ctrl.master && sync_s2 && !sync_fall_prev)
            begin
                // The first bit is already on the line when long sync is seen.
                bit_idx <= 8'h00;
                frame_seen <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit and receive shifting
    // ------------------------------------------------------------------
    assign load_word = format_word(fifo_out_valid ? fifo_out_data : 13'h0000, ctrl);
    assign cur_word = next_bit_idx[3:0] == 4'h0 ? load_word : tx_word;
    assign fifo_out_ready = bit_rise && next_hit.hit && next_bit_idx[3:0] == 4'h0;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_word <= 16'h0000;
            pcm_dout <= 1'b0;
            pcm_dout_oe <= 1'b0;
        end
        else if (!ctrl.enable)
        begin
            pcm_dout <= 1'b0;
            pcm_dout_oe <= 1'b0;
        end
        else if (bit_rise)
        begin
            tx_word <= cur_word;
            pcm_dout_oe <= next_hit.hit;
            // Default order is MSB first with the sample at the top.
            pcm_dout <= next_hit.hit &&
                cur_word[ctrl.lsb_first ? next_bit_idx[3:0] : 4'hf - next_bit_idx[3:0]];
        end
        else if (release_due)
        begin
            pcm_dout_oe <= 1'b0;
        end
    end

    // Releasing one cycle after the fall keeps the last bit valid at the partner's sample.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            release_due <= 1'b0;
        end
        else
        begin
            release_due <= bit_fall && bit_idx[3:0] == 4'hf;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            underrun <= 1'b0;
        end
        else if (fifo_out_ready && !fifo_out_valid)
        begin
            underrun <= 1'b1;
        end
        else if (reg_wr && addr == `PCM_REG_STATUS && pwdata[1])
        begin
            underrun <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_word <= 16'h0000;
            rx_done <= 1'b0;
            rx_ch <= 2'h0;
            for (int c = 0; c < `PCM_CHANNELS; c++)
            begin
                rx_sample[c] <= 13'h0000;
            end
        end
        else
        begin
            rx_done <= 1'b0;
            if (bit_fall && cur_hit.hit)
            begin
                rx_word[ctrl.lsb_first ? bit_idx[3:0] : 4'hf - bit_idx[3:0]] <= din_s2;
                if (bit_idx[3:0] == 4'hf)
                begin
                    rx_done <= 1'b1;
                    rx_ch <= cur_hit.ch;
                end
            end
            if (rx_done)
            begin
                rx_sample[rx_ch] <= extract(rx_word, ctrl.pos);
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_OE_ONLY_IN_HIT: assert property (@(posedge sys_clk) disable iff (rst)
        pcm_dout_oe |-> cur_hit.hit)
        else $error("Data output driven in an unassigned slot.");
    AST_RELEASE_LAST_BIT: assert property (@(posedge sys_clk) disable iff (rst)
        bit_fall && bit_idx[3:0] == 4'hf |=> ##1 !pcm_dout_oe)
        else $error("Data output not released after last bit fall.");
    AST_SAME_SLOT: assert property (@(posedge sys_clk) disable iff (rst)
        bit_fall && cur_hit.hit && bit_idx[3:0] == 4'hf |=> rx_done && rx_ch == $past(cur_hit.ch))
        else $error("Receive slot differs from transmit slot.");
    AST_SHORT_SYNC: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.master && !ctrl.long_sync && pcm_sync_out && !bit_rise |-> bit_idx == last_idx)
        else $error("Short sync outside last bit of frame.");
    AST_LONG_SYNC: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.master && ctrl.long_sync && bit_rise ##1 1'b1 |->
        pcm_sync_out == (bit_idx < `PCM_LONG_SYNC_BITS))
        else $error("Long sync not three bits from frame start.");
    AST_SLAVE_ALIGN: assert property (@(posedge sys_clk) disable iff (rst)
        bit_rise && pend_zero |=> bit_idx == 8'h00 && frame_seen)
        else $error("Slave did not start slot zero after sync.");
    AST_SLOT_STEP: assert property (@(posedge sys_clk) disable iff (rst)
        bit_rise && !next_zero && bit_idx[3:0] == 4'hf && bit_idx != 8'hff |=>
        bit_idx[3:0] == 4'h0 && bit_idx[7:4] == $past(bit_idx[7:4]) + 4'h1)
        else $error("Slot did not advance after sixteen bits.");
    AST_BURST_REQ: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(burst_active) |-> $past(ctrl.burst_req))
        else $error("Burst mode entered without request.");
endmodule : pcm_voice_port

`default_nettype wire

// [testbench/pcm_codec_model.sv]
// Purpose: Codec partner on the PCM link.
// Assumes: One watched slot; as master it frames 32 bits with short sync.
// Notes: Samples on falling edges, drives 1 ns after rising edges.
`timescale 1ns/10ps
`default_nettype none
// ----
// Codec
// ----
module pcm_codec_model (
    input wire logic rst,
    input wire logic drive,
    input wire logic long_sync,
    input wire logic pclk,
    input wire logic sync,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic [3:0] slot,
    input wire logic [15:0] word,
    output logic mclk = 0,
    output logic msync = 0,
    output logic din = 0,
    output logic got_stb = 0,
    output logic [15:0] got = 0,
    output logic [7:0] stray = 0
);
    int bitn = 1000;
    logic [4:0] mcnt = 0;
    logic ps = 0;
    logic sfl = 0;
    always @(posedge rst)
    begin
        bitn = 1000;
        mcnt = 0;
    end
    // The clock stands still while the device is master.
    always #40 mclk = drive & ~mclk;
    always @(posedge mclk)
    begin
        mcnt <= mcnt + 5'h01;
        msync <= (mcnt == 5'h1e);
    end
    always @(negedge pclk)
    begin
        sfl = sync;
        if (bitn / 16 == slot)
            got[15 - bitn % 16] = dout_oe ? dout : 1'bx;
        else if (dout_oe)
            stray = stray + 8'h01;
        got_stb = (bitn == slot * 16 + 15);
    end
    always @(posedge pclk)
    begin
        #1;
        got_stb = 0;
        bitn = (long_sync ? sync && !ps : sfl) ? 0 : bitn + 1;
        ps = sync;
        // Off the slot the line never keeps a stale bit.
        din = (bitn / 16 == slot) ? word[15 - bitn % 16] : ~din;
    end
endmodule : pcm_codec_model
`default_nettype wire

// [testbench/test_pcm_voice_port.sv]
// Purpose: Self-checking bench for the PCM voice port.
// Assumes: Codec partner on the link; APB master tasks here.
// Notes: Each run overfills the FIFO once, then drains it into underrun.
`timescale 1ns/10ps
`default_nettype none
`include "pcm_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: mismatch", $time); end end
// ----
// Bench
// ----
module test_pcm_voice_port;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, pcm_din, mclk, msync;
    logic [31:0] paddr, pwdata, prdata;
    logic pcm_clk_out, pcm_clk_oe, pcm_sync_out, pcm_sync_oe, pcm_dout, pcm_dout_oe;
    logic drive, long_sync, got_stb, lsbf;
    logic [1:0] fm, pos;
    logic [2:0] fv;
    logic [3:0] slot;
    logic [15:0] word, got;
    logic [7:0] stray;
    logic [64:0] rq[$];
    logic [64:0] e;
    logic [15:0] lq[$];
    int n_errors = 0, cmp_count = 0, ticks = 0, stalls = 0;
    wire logic clk_line = pcm_clk_oe ? pcm_clk_out : mclk;
    wire logic sync_line = pcm_sync_oe ? pcm_sync_out : msync;
    pcm_voice_port u_pcm_voice_port (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pcm_clk_in(clk_line), .pcm_clk_out,
        .pcm_clk_oe, .pcm_sync_in(sync_line), .pcm_sync_out, .pcm_sync_oe, .pcm_din,
        .pcm_dout, .pcm_dout_oe);
    pcm_codec_model u_pcm_codec_model (.rst, .drive, .long_sync, .pclk(clk_line),
        .sync(sync_line), .dout(pcm_dout), .dout_oe(pcm_dout_oe), .slot, .word, .mclk,
        .msync, .din(pcm_din), .got_stb, .got, .stray);
    initial
    begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        ticks++;
        if (psel && penable && pready === 1'b0)
            stalls++;
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = rq.pop_front();
            `CHK({pslverr, prdata & e[64:33]}, e[32:0])
        end
        if (ticks == 60000)
        begin
            n_errors++;
            close_out();
        end
    end
    always @(posedge got_stb)
        if (lq.size() > 0)
            `CHK(got, lq.pop_front())
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [31:0] a, input logic [32:0] x, input logic [31:0] m);
        rq.push_back({m, x});
        apb(1'b0, a, 32'h0);
    endtask : rd
    function automatic int idx(input int k);
        int p = 15 - k - pos;
        return (p >= 0 && p < 13) ? 12 - p : -1;
    endfunction : idx
    function automatic logic [15:0] fmt(input logic [12:0] s);
        logic [15:0] w;
        for (int k = 15; k >= 0; k--)
            if (idx(k) >= 0)
                w[k] = s[idx(k)];
            else
                w[k] = (fm == 2'h3) ? fv[(k + pos) % 16] : (fm == 2'h2) ? s[12] : fm[0];
        if (lsbf)
            w = {<<{w}};
        return w;
    endfunction : fmt
    function automatic logic [12:0] unfmt(input logic [15:0] w);
        logic [12:0] s;
        if (lsbf)
            w = {<<{w}};
        for (int k = 15; k >= 0; k--)
            if (idx(k) >= 0)
                s[idx(k)] = w[k];
        return s;
    endfunction : unfmt
    task automatic run(input logic slave);
        logic [12:0] smp;
        rst <= 1'b1;
        drive = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        slot = slave ? 4'($urandom % 2) : 4'($urandom % 16);
        word = 16'($urandom);
        apb(1'b1, `PCM_REG_SLOTMAP, {27'h0, 1'b1, slot});
        for (int i = 0; i < 5; i++)
        begin
            smp = 13'($urandom);
            lq.push_back(fmt(smp));
            if (i == 4)
            begin
                apb(1'b1, `PCM_REG_CTRL, {17'h0, fv, lsbf, pos, fm, !slave, 1'b0,
                    `PCM_RATE_HIGH, long_sync, !slave, 1'b1});
                drive = slave;
            end
            apb(1'b1, `PCM_REG_TXDATA, {19'h0, smp});
        end
        lq.push_back(fmt(13'h0));
        while (lq.size() > 0)
            @(posedge sys_clk);
        rd(`PCM_REG_RX0, {20'h0, unfmt(word)}, '1);
        rd(`PCM_REG_STATUS, {29'h0, 3'b101, !slave}, 32'hf);
        $display("link run done, slave %0d", slave);
    endtask : run
    initial
    begin
        {psel, penable, pwrite, rst, drive, long_sync} = 6'h04;
        {paddr, pwdata, slot, word} = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        void'($urandom(31));
        rd(`PCM_REG_CTRL, 33'h0, '1);
        rd(`PCM_REG_SLOTMAP, 33'h0, '1);
        rd(32'h100, {1'b1, 32'h0}, '1);
        $display("register test done");
        for (int i = 0; i < 4; i++)
        begin
            fm = 2'(i);
            long_sync = (i == 1);
            lsbf = i[1];
            pos = i ? 2'($urandom) : 2'h0;
            fv = 3'($urandom);
            run(i == 3);
        end
        `CHK(stray, 8'h00)
        `CHK(stalls > 0, 1'b1)
        close_out();
    end
endmodule : test_pcm_voice_port
`default_nettype wire
